//--- hw/analog_reference_pkg.sv
package analog_reference_pkg;
    localparam logic [7:0] ADDR_REF_CTRL     = 8'hD1;
    localparam logic [7:0] REF_CTRL_RESET    = 8'h00;
    localparam int         BIT_REF_SELECT    = 3;
    localparam int         BIT_TEMP_ENABLE   = 2;
    localparam int         BIT_BIAS_ENABLE   = 1;
    localparam logic [7:0] REF_CTRL_WR_MASK  = 8'h0E;
    localparam logic [3:0] POS_SEL_TEMP      = 4'h8;
    localparam int         CONV_SAR_CLOCKS   = 8;
    localparam int         RESULT_BITS       = 8;

    // register bus request from the core
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // stored control fields
    typedef struct packed {
        logic ref_select;
        logic temp_enable;
        logic bias_enable;
    } ref_ctrl_t;
endpackage : analog_reference_pkg

//--- hw/analog_reference_control.sv
`timescale 1ns/1ps

// control register for the analog reference, sensor and bias
// the converter itself sits elsewhere; this block only hands it
// its reference choice, sensor enable and bias enable
// sensor input number and conversion length are package constants
// that the converter side reads; nothing here counts conversions
// all state clears on srst; there is no other storage here
// a request is taken on the edge it is seen: no wait states
module analog_reference_control
(
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    input  wire analog_reference_pkg::sfr_req_t sfr_req,
    output logic [7:0]                         sfr_rdata,
    output logic                               sfr_hit,
    input  wire logic                          adc_enable,
    input  wire logic                          osc_enable,
    output logic                               reference_source_select,
    output logic                               temp_sensor_enable,
    output logic                               temp_sensor_out_en_n,
    output logic                               bias_generator_enable,
    output logic                               bias_stored
);
    import analog_reference_pkg::*;


    // stored fields, lowest register bit first
    // the field index is also the bit position in ref_ctrl_t
    localparam int FIELD_COUNT = 3;
    localparam int FIELD_BIAS  = 0;
    localparam int FIELD_TEMP  = 1;
    localparam int FIELD_REF   = 2;
    localparam int BYTE_BITS   = 8;

    // address compare for this register
    // one compare keeps the write and read paths in step
    function automatic logic addr_match
    (
        input logic [7:0] addr
    );
        return addr == ADDR_REF_CTRL;
    endfunction : addr_match

    // strobe qualified by the address compare
    // used for both the write and the read strobe
    function automatic logic strobe_hit
    (
        input logic       strobe,
        input logic [7:0] addr
    );
        return strobe && addr_match(addr);
    endfunction : strobe_hit

    // true for a register bit that holds a stored field
    // all other bits are don't-care on write and zero on read
    function automatic logic field_writable
    (
        input int position
    );
        return REF_CTRL_WR_MASK[position];
    endfunction : field_writable

    // register bit that holds a given stored field
    // kept in one place so the bit map cannot drift
    function automatic int field_position
    (
        input int field
    );
        int position;
        case (field)
            FIELD_BIAS:
                position = BIT_BIAS_ENABLE;
            FIELD_TEMP:
                position = BIT_TEMP_ENABLE;
            FIELD_REF:
                position = BIT_REF_SELECT;
            default:
                // no such field; bit 0 is never stored
                position = 0;
        endcase
        return position;
    endfunction : field_position

    // stored field held in a register bit (inverse of the above)
    // only called for bits that field_writable accepts
    function automatic int position_field
    (
        input int position
    );
        int field;
        case (position)
            BIT_BIAS_ENABLE:
                field = FIELD_BIAS;
            BIT_TEMP_ENABLE:
                field = FIELD_TEMP;
            BIT_REF_SELECT:
                field = FIELD_REF;
            default:
                // unreachable for stored bits
                field = 0;
        endcase
        return field;
    endfunction : position_field

    // decoded request qualifiers
    logic                   addr_hit;
    logic                   wr_hit;
    logic                   rd_hit;

    // write data with the don't-care bits already cleared
    logic [BYTE_BITS-1:0]   wdata_kept;

    // stored fields as a vector, with next and reset values
    logic [FIELD_COUNT-1:0] field_q;
    logic [FIELD_COUNT-1:0] next_field;
    logic [FIELD_COUNT-1:0] field_reset;

    // the same fields viewed through the package struct
    ref_ctrl_t              ctrl;

    // byte shown on a read, and the next read data
    logic [BYTE_BITS-1:0]   reg_image;
    logic [BYTE_BITS-1:0]   next_rdata;

    // every user that needs the bias generator running
    logic [3:0]             bias_users;

    // request decode
    assign addr_hit   = addr_match(sfr_req.addr);
    assign wr_hit     = strobe_hit(sfr_req.wr, sfr_req.addr);
    assign rd_hit     = strobe_hit(sfr_req.rd, sfr_req.addr);

    // bits 7..4 and 0 are don't-care on write
    // masking here keeps the field loop free of special cases
    assign wdata_kept = sfr_req.wdata & REF_CTRL_WR_MASK;

    // one stored field per pass: next value, reset value, flop
    // a field changes only on a write or on reset
    for (genvar i = 0; i < FIELD_COUNT; i++)
    begin : g_field
        // a write takes the field's own bit, otherwise hold
        assign next_field[i]  = wr_hit ? wdata_kept[field_position(i)]
                                       : field_q[i];

        // reset value from the same register bit
        assign field_reset[i] = REF_CTRL_RESET[field_position(i)];

        // field flop; a write shows after the next edge
        always_ff @(posedge clk_sys)
        begin
            if (srst)
                field_q[i] <= field_reset[i];
            else
                field_q[i] <= next_field[i];
        end
    end : g_field

    // struct view used by the outputs
    assign ctrl = ref_ctrl_t'(field_q);

    // read image: a stored field or a hard zero per bit
    // unused bits are tied, so no write can ever reach them
    for (genvar b = 0; b < BYTE_BITS; b++)
    begin : g_image
        if (field_writable(b))
        begin : g_stored
            assign reg_image[b] = field_q[position_field(b)];
        end : g_stored
        else
        begin : g_zero
            assign reg_image[b] = 1'b0;
        end : g_zero
    end : g_image

    // read data: the image after a read, zero otherwise
    // zero when idle so the core can merge many blocks with an or
    assign next_rdata = rd_hit ? reg_image : 8'h00;

    // read data flop; a write in the same cycle is seen next read
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= next_rdata;
    end

    // hit flag for the core's read multiplexer
    assign sfr_hit                 = addr_hit;

    // reference mux: low picks the pin, high the supply
    assign reference_source_select = ctrl.ref_select;

    // sensor power switch
    assign temp_sensor_enable      = ctrl.temp_enable;

    // stored bias bit as software last wrote it
    assign bias_stored             = ctrl.bias_enable;

    // sensor buffer floats while off; low means driving
    // a conversion of a floating sensor gives a meaningless result
    assign temp_sensor_out_en_n    = ~ctrl.temp_enable;

    // users of the bias generator
    assign bias_users = {
        osc_enable,
        ctrl.temp_enable,
        adc_enable,
        ctrl.bias_enable
    };

    // bias forced on while any user is on, whatever the stored bit
    // software should still keep the stored bit set for the converter
    assign bias_generator_enable   = |bias_users;
endmodule : analog_reference_control

//--- verif/ref_props.sv
`timescale 1ns/1ps
module ref_props
(
    input wire logic                           clk_sys,
    input wire logic                           srst,
    input wire analog_reference_pkg::sfr_req_t sfr_req,
    input wire logic                           sfr_hit,
    input wire logic                           adc_enable,
    input wire logic                           osc_enable,
    input wire logic                           reference_source_select,
    input wire logic                           temp_sensor_enable,
    input wire logic                           temp_sensor_out_en_n,
    input wire logic                           bias_stored,
    input wire logic                           bias_generator_enable,
    input wire logic [7:0]                     sfr_rdata
);
default clocking @(posedge clk_sys); endclocking
default disable iff (srst);
hit_decode_a: assert property (sfr_hit == (sfr_req.addr == 8'hD1))
    else $error("address decode wrong");
sensor_float_a: assert property (temp_sensor_out_en_n == !temp_sensor_enable)
    else $error("sensor float wrong");
write_update_a: assert property (sfr_req.wr && sfr_hit |=>
    {reference_source_select, temp_sensor_enable, bias_stored} == $past(sfr_req.wdata[3:1]))
    else $error("write not applied");
hold_value_a: assert property (!(sfr_req.wr && sfr_hit) |=>
    $stable({reference_source_select, temp_sensor_enable, bias_stored}))
    else $error("field changed without write");
reset_clear_a: assert property (disable iff (1'b0) srst |=>
    ({reference_source_select, temp_sensor_enable, bias_stored} == 3'h0) && (sfr_rdata == 8'h00))
    else $error("reset did not clear");
read_data_a: assert property (sfr_req.rd && sfr_hit |=> sfr_rdata == {4'h0,
    $past(reference_source_select), $past(temp_sensor_enable), $past(bias_stored), 1'b0})
    else $error("read data wrong");
idle_zero_a: assert property (!(sfr_req.rd && sfr_hit) |=> sfr_rdata == 8'h00)
    else $error("read data not zero");
bias_force_a: assert property (bias_generator_enable == (bias_stored | adc_enable
    | osc_enable | temp_sensor_enable)) else $error("bias not forced");
unused_zero_a: assert property (!sfr_rdata[0] && !sfr_rdata[7:4]) else $error("bad rd");
endmodule : ref_props
bind analog_reference_control ref_props chk(.*);

//--- verif/core_model.sv
`timescale 1ns/1ps
module core_model(input wire logic clk_sys, output analog_reference_pkg::sfr_req_t q);
initial q = '0;
// one-cycle strobe, released next edge
task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1 q = '{w, !w, a, d};
    @(posedge clk_sys) #1 q = '0;
endtask : access
endmodule : core_model

//--- verif/analog_reference_control_test.sv
`timescale 1ns/1ps
module analog_reference_control_test;
import analog_reference_pkg::*;
logic clk_sys = 0, srst = 1, adc = 0, osc = 0, s, t, n, b;
logic [7:0] rd;
sfr_req_t q;
int failures = 0, comparisons = 0;
always #5 clk_sys = ~clk_sys;
core_model core(.clk_sys(clk_sys), .q(q));
analog_reference_control dut(.clk_sys(clk_sys), .srst(srst), .sfr_req(q), .sfr_rdata(rd),
    .sfr_hit(), .adc_enable(adc), .osc_enable(osc), .reference_source_select(s),
    .temp_sensor_enable(t), .temp_sensor_out_en_n(n), .bias_generator_enable(b),
    .bias_stored());
task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
        failures++;
        $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
endtask : check
task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask : final_report
initial
begin
    #20000 failures++;
    final_report;
end
// every field pattern, with converter and oscillator toggled
initial
begin
    repeat (10) @(posedge clk_sys);
    #1 srst = 0;
    core.access(0, 8'hD1, 8'h00);
    check(rd, 8'h00);
    for (int v = 0; v < 32; v++)
    begin
        adc = v[0];
        osc = v[4];
        core.access(1, 8'hD1, {4'hF, v[3:0]});
        check({s, t, n, b}, {v[3], v[2], !v[2], |{v[2:0], v[4]}});
        core.access(0, 8'hD1, 8'h00);
        check(rd, 8'(v[3:1]) << 1);
        core.access(0, 8'hD0, 8'h00);
        check(rd, 8'h00);
    end
    $display("pattern test done");
    adc = 0;
    osc = 0;
    core.access(1, 8'hD1, 8'h0E);
    check({s, t, n, b}, 8'h0D);
    srst = 1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 0;
    check({s, t, n, b}, 8'h02);
    core.access(0, 8'hD1, 8'h00);
    check(rd, 8'h00);
    $display("reset test done");
    final_report;
end
endmodule : analog_reference_control_test
